// ===== design/udc_pkg.sv
// udc_pkg: shared constants and carrier types of the dual-clock up/down counter
package udc_pkg;

  localparam int unsigned UDC_WIDTH     = 4;
  localparam logic [3:0]  UDC_ZERO      = 4'h0;
  localparam logic [3:0]  UDC_BIN_MAX   = 4'hF;
  localparam logic [3:0]  UDC_DEC_MAX   = 4'h9;
  localparam int unsigned UDC_SYNC_DEPTH = 2;
  localparam logic [1:0]  UDC_SYNC_RST  = 2'h3;
  localparam logic        UDC_PIN_IDLE  = 1'b1;

  // count variant chosen at build time
  typedef enum logic {
    UDC_MODE_DECADE,
    UDC_MODE_BINARY
  } udc_mode_t;

  // raw pin inputs from the driving logic
  typedef struct packed {
    logic       count_up;
    logic       count_down;
    logic       load_n;
    logic       clear_in;
    logic [3:0] data;
  } udc_pins_t;

  // counter outputs
  typedef struct packed {
    logic [3:0] q;
    logic       carry_out_n;
    logic       borrow_out_n;
  } udc_outs_t;

endpackage : udc_pkg

// ===== design/udc_sync.sv
// udc_sync: two-flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module udc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  // level
  input  wire logic async_i,
  output logic      sync_o
);

  typedef struct packed {
    logic meta;
    logic sync;
  } udc_sync_st_t;

  udc_sync_st_t st_r;
  udc_sync_st_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = async_i;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.sync;

endmodule // udc_sync

// ===== design/udc_counter.sv
// udc_counter: dual-clock synchronous up/down counter, decade or binary
//
// Contract
// R1: state changes only on a count input rising edge
// R2: up edge increments, down edge decrements, other high
// R3: driver holds the idle count input high
// R4: build-time decade or binary variant
// R5: decade wraps nine-zero with carry/borrow
// R6: binary wraps fifteen-zero with carry/borrow
// R7: load low makes outputs follow data
// R8: clear high zeroes outputs, overrides everything (borrow still goes low under clear while count-down is low)
// R9: carry pulse width equals causing up pulse
// R10: borrow pulse width equals causing down pulse
// R11: carry/borrow drive next stage count inputs
// R12: all state bits update on one edge
// R13: carry low when up low at max; borrow likewise
// R14: state after reset undefined until clear/load (reset here loads a zero count)
`timescale 1ns/1ps
module udc_counter
  import udc_pkg::*;
#(
  parameter udc_mode_t MODE = UDC_MODE_BINARY
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // pins from the driving logic
  input  wire udc_pkg::udc_pins_t pins_i,
  // counter outputs
  output logic [3:0]       q_o,
  output logic             carry_out_n_o,
  output logic             borrow_out_n_o
);

  import udc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic            up_s;
  logic            down_s;
  logic            load_n_s;
  logic            clear_s;
  logic [3:0]      data_s;

  udc_sync #(.RST_VAL(UDC_PIN_IDLE)) u_sync_up (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (pins_i.count_up),
    .sync_o    (up_s)
  );

  udc_sync #(.RST_VAL(UDC_PIN_IDLE)) u_sync_down (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (pins_i.count_down),
    .sync_o    (down_s)
  );

  udc_sync #(.RST_VAL(UDC_PIN_IDLE)) u_sync_load (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (pins_i.load_n),
    .sync_o    (load_n_s)
  );

  udc_sync #(.RST_VAL(1'b0)) u_sync_clear (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (pins_i.clear_in),
    .sync_o    (clear_s)
  );

  // data bits sync one by one, so a word changed while load is low may
  // show a mixed value for one clock before the count settles on it
  genvar gi;
  generate
    for (gi = 0; gi < UDC_WIDTH; gi++) begin : g_data_sync
      udc_sync #(.RST_VAL(1'b0)) u_sync_data (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   (pins_i.data[gi]),
        .sync_o    (data_s[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // state

  localparam logic [3:0] MAX_VAL = (MODE == UDC_MODE_DECADE) ? UDC_DEC_MAX : UDC_BIN_MAX;  // [R4]

  typedef struct packed {
    logic      up_d;
    logic      down_d;
    logic [3:0] cnt;
    udc_outs_t outs;
  } udc_st_t;

  udc_st_t st_r;
  udc_st_t st_nxt;

  logic up_rise;
  logic down_rise;

  assign up_rise   = up_s & ~st_r.up_d;    // [R1]
  assign down_rise = down_s & ~st_r.down_d; // [R1]

  always_comb begin
    st_nxt        = st_r;
    st_nxt.up_d   = up_s;
    st_nxt.down_d = down_s;
    if (clear_s) begin
      st_nxt.cnt = UDC_ZERO;                 // [R8]
    end else if (!load_n_s) begin
      st_nxt.cnt = data_s;                   // [R7]
    end else if (up_rise && down_s) begin  // [R2] [R3]
      // out-of-range values past max wrap to zero like the decade steering logic
      if (st_r.cnt >= MAX_VAL) begin
        st_nxt.cnt = UDC_ZERO;               // [R5] [R6]
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;        // [R12]
      end
    end else if (down_rise && up_s) begin  // [R2] [R3]
      if (st_r.cnt == UDC_ZERO) begin
        st_nxt.cnt = MAX_VAL;                // [R5] [R6]
      end else if (st_r.cnt > MAX_VAL) begin
        st_nxt.cnt = st_r.cnt - 4'h1;
      end else begin
        st_nxt.cnt = st_r.cnt - 4'h1;        // [R12]
      end
    end
    // outputs follow the next state in the same edge, so all bits move together
    st_nxt.outs.q = st_nxt.cnt;              // [R12]
    // carry/borrow are combinational gates of the level in the real part; here
    // registered from the synced level so the pulse tracks the count input width
    st_nxt.outs.carry_out_n  = ~(~up_s && (st_nxt.cnt == MAX_VAL) && !clear_s);  // [R9] [R13]
    st_nxt.outs.borrow_out_n = ~(~down_s && (st_nxt.cnt == UDC_ZERO));           // [R10] [R13]
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      // reset gives a defined zero; a user must still clear or load first
      st_r.up_d              <= UDC_PIN_IDLE;
      st_r.down_d            <= UDC_PIN_IDLE;
      st_r.cnt               <= UDC_ZERO;           // [R14]
      st_r.outs.q            <= UDC_ZERO;
      st_r.outs.carry_out_n  <= UDC_PIN_IDLE;
      st_r.outs.borrow_out_n <= UDC_PIN_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // both idle high, so a carry or borrow feeds the next stage directly
  assign q_o            = st_r.outs.q;
  assign carry_out_n_o  = st_r.outs.carry_out_n;   // [R11]
  assign borrow_out_n_o = st_r.outs.borrow_out_n;  // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence up_edge_s;
    up_rise && down_s && load_n_s && !clear_s;
  endsequence

  sequence down_edge_s;
    down_rise && up_s && load_n_s && !clear_s;
  endsequence

  // no clear and no load: only the count inputs steer the state
  sequence quiet_s;
    load_n_s && !clear_s;
  endsequence

  // carry low and the count-up level still low
  sequence carry_held_s;
    !carry_out_n_o && !up_s;
  endsequence

  // carry low while the count-up level rises with count-down high
  sequence carry_ends_s;
    !carry_out_n_o && up_rise && down_s;
  endsequence

  sequence borrow_held_s;
    !borrow_out_n_o && !down_s;
  endsequence

  sequence borrow_ends_s;
    !borrow_out_n_o && down_rise && up_s;
  endsequence

  // an edge on one count input while the other is held low
  sequence up_refused_s;
    up_rise && !down_s;
  endsequence

  sequence down_refused_s;
    down_rise && !up_s;
  endsequence

  clear_zero_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R8]
    clear_s |=> (q_o == UDC_ZERO))
    else $error("clear did not zero the count");

  load_follow_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R7]
    (!clear_s && !load_n_s) |=> (q_o == $past(data_s)))
    else $error("load did not copy data");

  hold_no_edge_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R1]
    (!clear_s && load_n_s && !up_rise && !down_rise) |=> $stable(q_o))
    else $error("count moved without an edge");

  up_step_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R2]
    up_edge_s ##0 (st_r.cnt < MAX_VAL) |=> (q_o == $past(st_r.cnt) + 4'h1))
    else $error("up edge did not increment");

  down_step_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R2]
    down_edge_s ##0 (st_r.cnt != UDC_ZERO) |=> (q_o == $past(st_r.cnt) - 4'h1))
    else $error("down edge did not decrement");

  up_wrap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R5]
    up_edge_s ##0 (st_r.cnt == MAX_VAL) |=> (q_o == UDC_ZERO))
    else $error("up wrap did not reach zero");

  down_wrap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R6]
    down_edge_s ##0 (st_r.cnt == UDC_ZERO) |=> (q_o == MAX_VAL))
    else $error("down wrap did not reach max");

  carry_level_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R9]
    (!up_s && !clear_s && load_n_s && (st_r.cnt == MAX_VAL)) |=> !carry_out_n_o)
    else $error("carry missing while up low at max");

  borrow_level_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R10]
    (!down_s && !clear_s && load_n_s && (st_r.cnt == UDC_ZERO)) |=> !borrow_out_n_o)
    else $error("borrow missing while down low at zero");

  carry_idle_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R13]
    up_s |=> carry_out_n_o)
    else $error("carry asserted with up high");

  ////////////////////////////////////////////////////////////////////////////
  // assertions: borrow idle level, pulse width of carry and borrow

  borrow_idle_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R13]
    down_s |=> borrow_out_n_o)
    else $error("borrow asserted with down high");

  carry_track_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R9]
    quiet_s ##0 carry_held_s
    |=> !carry_out_n_o)
    else $error("carry ended while up still low");

  carry_end_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R9]
    quiet_s ##0 carry_ends_s
    |=> (carry_out_n_o && (q_o == UDC_ZERO)))
    else $error("carry did not end with the wrap");

  borrow_track_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R10]
    quiet_s ##0 borrow_held_s
    |=> !borrow_out_n_o)
    else $error("borrow ended while down still low");

  borrow_end_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R10]
    quiet_s ##0 borrow_ends_s
    |=> (borrow_out_n_o && (q_o == MAX_VAL)))
    else $error("borrow did not end with the wrap");

  ////////////////////////////////////////////////////////////////////////////
  // assertions: refused edges, cascade and stepping

  refused_up_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R2]
    quiet_s ##0 up_refused_s
    |=> $stable(q_o))
    else $error("up edge counted while down low");

  refused_down_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R2]
    quiet_s ##0 down_refused_s
    |=> $stable(q_o))
    else $error("down edge counted while up low");

  not_both_low_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R11]
    carry_out_n_o || borrow_out_n_o)
    else $error("carry and borrow low together");

  carry_at_max_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R13]
    !carry_out_n_o |-> (q_o == MAX_VAL))
    else $error("carry low away from max");

  borrow_at_zero_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R13]
    !borrow_out_n_o |-> (q_o == UDC_ZERO))
    else $error("borrow low away from zero");

  clear_carry_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R8]
    clear_s |=> carry_out_n_o)
    else $error("carry asserted under clear");

  over_range_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R4]
    up_edge_s ##0 (st_r.cnt > MAX_VAL)
    |=> (q_o == UDC_ZERO))
    else $error("out of range count did not wrap");

  single_step_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)  // [R12]
    quiet_s |=> ($stable(q_o)
      || (q_o == $past(q_o) + 4'h1)
      || (q_o == $past(q_o) - 4'h1)
      || (q_o == UDC_ZERO) || (q_o == MAX_VAL)))
    else $error("count jumped by more than one step");

endmodule // udc_counter

// ===== tb/udc_drv.sv
// udc_drv: driving-logic model for count pulses, load and clear
`timescale 1ns/1ps
module udc_drv (
  input  wire logic          sys_clk_i,
  output udc_pkg::udc_pins_t pins_o
);
  import udc_pkg::*;
  // idle: both count inputs high, load off, clear off
  initial pins_o = 8'hE0;
  // callers hold each level 4 clocks, two more than the two-stage pin syncs need
  task automatic press(input logic up, input logic other);
    @(posedge sys_clk_i);
    if (up) {pins_o.count_up, pins_o.count_down} <= {1'b0, other};
    else {pins_o.count_up, pins_o.count_down} <= {other, 1'b0};
  endtask
  task automatic rel(input logic up);
    @(posedge sys_clk_i);
    if (up) pins_o.count_up <= 1'b1;
    else pins_o.count_down <= 1'b1;
  endtask
  task automatic ctl(input logic load_n, input logic clr, input logic [3:0] d);
    @(posedge sys_clk_i);
    {pins_o.load_n, pins_o.clear_in, pins_o.data} <= {load_n, clr, d};
  endtask
endmodule // udc_drv

// ===== tb/dual_clock_updown_counter_bench.sv
// dual_clock_updown_counter_bench: binary, decade and cascaded counters
`timescale 1ns/1ps
module dual_clock_updown_counter_bench;
  import udc_pkg::*;
  logic      sys_clk_i, reset_i;
  udc_pins_t pins, pins_hi;
  logic [3:0] q_bin, q_dec, q_hi, e_bin, e_dec, e_hi;
  logic      co_bin, bo_bin, co_dec, bo_dec;
  int        miscompares, samples_checked, cycles;
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  udc_drv drv (.sys_clk_i(sys_clk_i), .pins_o(pins));
  // upper stage counts straight from the lower stage's carry and borrow
  assign pins_hi = {co_bin, bo_bin, pins[5:0]};
  udc_counter #(.MODE(UDC_MODE_BINARY)) uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .pins_i(pins), .q_o(q_bin), .carry_out_n_o(co_bin), .borrow_out_n_o(bo_bin));
  udc_counter #(.MODE(UDC_MODE_DECADE)) uut_dec (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .pins_i(pins), .q_o(q_dec), .carry_out_n_o(co_dec), .borrow_out_n_o(bo_dec));
  udc_counter #(.MODE(UDC_MODE_BINARY)) uut_hi (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .pins_i(pins_hi), .q_o(q_hi), .carry_out_n_o(), .borrow_out_n_o());
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  function automatic logic [3:0] nx(logic [3:0] v, logic up, logic [3:0] mx);
    if (up) return (v >= mx) ? UDC_ZERO : v + 4'h1;
    return (v == UDC_ZERO) ? mx : v - 4'h1;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_clear;
    drv.ctl(1'b0, 1'b1, 4'hA);
    drv.press(1'b1, 1'b1);
    settle(4);
    drv.rel(1'b1);
    settle(7);
    {e_bin, e_dec, e_hi} = 12'h000;
    check(q_bin, e_bin);
    check(q_dec, e_dec);
    check(q_hi, e_hi);
    drv.ctl(1'b1, 1'b0, 4'h0);
  endtask
  task automatic t_load(input logic [3:0] d);
    drv.ctl(1'b0, 1'b0, ~d);
    drv.ctl(1'b0, 1'b0, d);
    settle(4);
    check(q_bin, d);
    check(q_dec, d);
    drv.ctl(1'b1, 1'b0, d);
    {e_bin, e_dec, e_hi} = {d, d, d};
  endtask
  task automatic t_step(input logic up);
    drv.press(up, 1'b1);
    settle(4);
    check(co_bin, !(up && e_bin == UDC_BIN_MAX));
    check(bo_bin, !(!up && e_bin == UDC_ZERO));
    check(co_dec, !(up && e_dec == UDC_DEC_MAX));
    check(bo_dec, !(!up && e_dec == UDC_ZERO));
    if (e_bin == (up ? UDC_BIN_MAX : UDC_ZERO)) e_hi = nx(e_hi, up, UDC_BIN_MAX);
    e_bin = nx(e_bin, up, UDC_BIN_MAX);
    e_dec = nx(e_dec, up, UDC_DEC_MAX);
    drv.rel(up);
    settle(4);
    check({co_bin, bo_bin, co_dec, bo_dec}, 4'hF);
    check(q_bin, e_bin);
    check(q_dec, e_dec);
    settle(3);
    check(q_hi, e_hi);
  endtask
  task automatic t_refused;
    for (int k = 0; k < 2; k++) begin
      drv.press(k[0], 1'b0);
      settle(4);
      drv.rel(k[0]);
      settle(4);
      check(q_bin, e_bin);
      drv.rel(!k[0]);
      settle(4);
      e_bin = nx(e_bin, !k[0], UDC_BIN_MAX);
      check(q_bin, e_bin);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles >= 5000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    reset_i = 1'b1;
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_clear();
    for (int i = 0; i < 2; i++) begin
      t_load(i ? 4'h7 : 4'hD);
      repeat (5) t_step(1'b1);
      repeat (5) t_step(1'b0);
    end
    t_refused();
    close_out();
  end
endmodule // dual_clock_updown_counter_bench
